// File: omp_pkg.sv
package omp_pkg;

  // two-wire device addresses, 7-bit form of the 8-bit A0h and A2h
  localparam logic [6:0] ID_DEV_ADDR     = 7'h50;
  localparam logic [6:0] DIAG_DEV_ADDR   = 7'h51;
  localparam int         NUM_MON         = 5;
  localparam logic [7:0] LIVE_BASE       = 8'h60;
  localparam logic [7:0] LIVE_LAST       = 8'h69;
  localparam logic [7:0] STATUS_BYTE     = 8'h6e;
  localparam logic [7:0] ALARM_BYTE      = 8'h70;
  localparam logic [7:0] WARN_BYTE       = 8'h74;
  localparam int         THR_STRIDE      = 8;
  localparam int         THR_HI_ALM      = 0;
  localparam int         THR_LO_ALM      = 2;
  localparam int         THR_HI_WRN      = 4;
  localparam int         THR_LO_WRN      = 6;
  localparam int         ALM_BIAS_HI     = 5;

  // wishbone byte offsets
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_PINS        = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT    = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK    = 8'h0c;
  localparam logic [7:0] REG_MON_BASE    = 8'h10;
  localparam logic [7:0] REG_FLAGS       = 8'h24;
  localparam logic [7:0] REG_MEM_ADDR    = 8'h28;
  localparam logic [7:0] REG_MEM_DATA    = 8'h2c;

  localparam int         CTRL_ID_WP      = 0;
  localparam int         CTRL_DIAG_WP    = 1;
  localparam int         CTRL_SOFT_TXOFF = 2;
  localparam logic [2:0] CTRL_RESET      = 3'h1;

  localparam int         IRQ_HOST_WR     = 0;
  localparam int         IRQ_FAULT       = 1;
  localparam int         IRQ_LOS         = 2;
  localparam int         IRQ_ALARM       = 3;

  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         TX_OFF_MAX_NS   = 10000;
  localparam int         TX_OFF_MAX_CYC  = TX_OFF_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_ADDR  = 8'h02,
    ST_ACK_A = 8'h04,
    ST_WORD  = 8'h08,
    ST_ACK_B = 8'h10,
    ST_WRITE = 8'h20,
    ST_READ  = 8'h40,
    ST_RACK  = 8'h80
  } omp_i2c_st_t;

  typedef struct packed {
    logic m;
    logic s;
  } omp_sync_t;

  typedef logic [127:0][7:0] omp_diag_mem_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } omp_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } omp_wb_rsp_t;

  typedef struct packed {
    omp_sync_t               scl;
    omp_sync_t               sda;
    logic                    scl_d;
    logic                    sda_d;
    omp_sync_t               fault;
    omp_sync_t               txd;
    omp_sync_t               sd;
    omp_sync_t               rxd;
    logic                    fault_d;
    logic                    sd_d;
    omp_i2c_st_t             st;
    logic [3:0]              cnt;
    logic [7:0]              sh;
    logic                    rw;
    logic                    map;
    logic [7:0]              ptr;
    logic                    nack;
    logic                    sda_oe_n;
    logic [2:0]              ctrl;
    logic [3:0]              irq_stat;
    logic [3:0]              irq_mask;
    logic [NUM_MON-1:0][15:0] mon;
    logic [9:0]              alm;
    logic [9:0]              wrn;
    logic                    mem_sel;
    logic [7:0]              mem_adr;
    logic [255:0][7:0]       id_mem;
    omp_diag_mem_t           dg_mem;
    omp_wb_rsp_t             rsp;
    logic                    tx_fault;
    logic                    tx_en;
    logic                    rx_signal_lost_out;
    logic                    rx_data;
    logic                    irq;
  } omp_state_t;

endpackage

// File: omp_mgmt_port.sv
// Notes on behaviour
// - fault output high on any laser fault
// - transmit-off input high or open disables laser
// - laser off within 10 us of disable
// - signal-lost output high when no signal
// - received data passed only while signal present
// - module-present pin held at ground
// - identification map answers at address A0h
// - diagnostic map answers at address A2h
// - capture on rising edge, honour write protection
// - change driven data on falling clock edge
// - data line two-way, start/stop framed by host
// - byte words, single or sequential access
// - live readings visible in diagnostic map
// - alarm and warning flags outside normal range
// - diagnostic values reported already calibrated
//
// Design decisions made here: the Wishbone slave port and the address map.
module omp_mgmt_port (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire omp_pkg::omp_wb_req_t wb_i,
  output omp_pkg::omp_wb_rsp_t      wb_o,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_n_o,
  output logic                      module_present_pin_o,
  output logic                      module_present_oe_n_o,
  input  wire logic                 laser_fault_i,
  output logic                      tx_fault_o,
  input  wire logic                 tx_disable_i,
  output logic                      tx_laser_en_o,
  input  wire logic                 rx_signal_detect_i,
  input  wire logic                 rx_data_i,
  output logic                      rx_signal_lost_out_o,
  output logic                      rx_data_o,
  output logic                      irq_o
);
  import omp_pkg::*;

  omp_state_t  s_reg;
  omp_state_t  s_next;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        byte_done;
  logic        i2c_store;
  logic        wr_blocked;
  logic [9:0]  alm_c;
  logic [9:0]  wrn_c;

  function automatic logic dev_match(input logic [6:0] a);
    return (a == ID_DEV_ADDR) || (a == DIAG_DEV_ADDR);
  endfunction

  function automatic logic [15:0] thr(input omp_diag_mem_t m, input int idx);
    return {m[7'(idx)], m[7'(idx + 1)]};
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // one byte of either map as seen by the host and by software
  function automatic logic [7:0] rd_byte(input omp_state_t st, input logic map, input logic [7:0] a);
    logic [7:0] idx;
    idx = a - LIVE_BASE;
    if (!map) begin
      return st.id_mem[a];
    end
    if (a[7]) begin
      return 8'h00;
    end
    if (a >= LIVE_BASE && a <= LIVE_LAST) begin
      // values are stored calibrated, so they go out untouched
      return idx[0] ? st.mon[idx[3:1]][7:0] : st.mon[idx[3:1]][15:8];
    end
    if (a == STATUS_BYTE) begin
      return {st.txd.s, st.ctrl[CTRL_SOFT_TXOFF], 3'h0, st.tx_fault, st.rx_signal_lost_out, 1'b0};
    end
    if (a == ALARM_BYTE) begin
      return st.alm[9:2];
    end
    if (a == ALARM_BYTE + 8'h01) begin
      return {st.alm[1:0], 6'h00};
    end
    if (a == WARN_BYTE) begin
      return st.wrn[9:2];
    end
    if (a == WARN_BYTE + 8'h01) begin
      return {st.wrn[1:0], 6'h00};
    end
    return st.dg_mem[a[6:0]];
  endfunction

  // the clock is only ever sampled, never driven
  assign scl_rise  = s_reg.scl.s && !s_reg.scl_d;
  assign scl_fall  = !s_reg.scl.s && s_reg.scl_d;
  assign bus_start = s_reg.scl.s && s_reg.scl_d && s_reg.sda_d && !s_reg.sda.s;
  assign bus_stop  = s_reg.scl.s && s_reg.scl_d && !s_reg.sda_d && s_reg.sda.s;
  assign byte_done = scl_fall && (s_reg.cnt == 4'h8);
  assign i2c_store = !bus_start && !bus_stop && byte_done && (s_reg.st == ST_WRITE);
  // thresholds and the live area are protected separately from the id map
  assign wr_blocked = s_reg.map ? (s_reg.ctrl[CTRL_DIAG_WP] || s_reg.ptr >= LIVE_BASE)
                                : s_reg.ctrl[CTRL_ID_WP];

  // comparison is unsigned: a signed temperature needs offset-coded thresholds
  for (genvar p = 0; p < NUM_MON; p++) begin : g_flags
    assign alm_c[9-2*p] = s_reg.mon[p] > thr(s_reg.dg_mem, p*THR_STRIDE + THR_HI_ALM);
    assign alm_c[8-2*p] = s_reg.mon[p] < thr(s_reg.dg_mem, p*THR_STRIDE + THR_LO_ALM);
    assign wrn_c[9-2*p] = s_reg.mon[p] > thr(s_reg.dg_mem, p*THR_STRIDE + THR_HI_WRN);
    assign wrn_c[8-2*p] = s_reg.mon[p] < thr(s_reg.dg_mem, p*THR_STRIDE + THR_LO_WRN);
  end

  always_comb begin
    logic        load_rd;
    logic        wb_hit;
    logic [31:0] wm;
    logic [31:0] rd;
    logic [3:0]  ev;
    logic [3:0]  clr;
    logic [7:0]  rbyte;
    load_rd = 1'b0;
    wb_hit  = 1'b0;
    wm      = lane_mask(wb_i.sel);
    rd      = 32'h0;
    ev      = 4'h0;
    clr     = 4'h0;
    rbyte   = 8'h00;
    s_next  = s_reg;

    s_next.scl.m  = scl_i;
    s_next.scl.s  = s_reg.scl.m;
    s_next.scl_d  = s_reg.scl.s;
    s_next.sda.m  = sda_i;
    s_next.sda.s  = s_reg.sda.m;
    s_next.sda_d  = s_reg.sda.s;
    s_next.fault  = '{m: laser_fault_i, s: s_reg.fault.m};
    s_next.txd    = '{m: tx_disable_i, s: s_reg.txd.m};
    s_next.sd     = '{m: rx_signal_detect_i, s: s_reg.sd.m};
    s_next.rxd    = '{m: rx_data_i, s: s_reg.rxd.m};
    s_next.fault_d = s_reg.fault.s;
    s_next.sd_d    = s_reg.sd.s;

    // a start or stop may interrupt any state, so it is checked first
    if (bus_start) begin
      s_next.st       = ST_ADDR;
      s_next.cnt      = 4'h0;
      s_next.sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      s_next.st       = ST_IDLE;
      s_next.sda_oe_n = 1'b1;
    end else begin
      unique case (s_reg.st)
        ST_IDLE: begin
        end
        ST_ADDR, ST_WORD, ST_WRITE: begin
          if (scl_rise) begin
            s_next.sh  = {s_reg.sh[6:0], s_reg.sda.s};
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (byte_done) begin
            s_next.cnt = 4'h0;
            if (s_reg.st == ST_ADDR) begin
              if (dev_match(s_reg.sh[7:1])) begin
                s_next.map      = s_reg.sh[1];
                s_next.rw       = s_reg.sh[0];
                s_next.sda_oe_n = 1'b0;
                s_next.st       = ST_ACK_A;
              end else begin
                s_next.st = ST_IDLE;
              end
            end else begin
              s_next.sda_oe_n = 1'b0;
              s_next.st       = ST_ACK_B;
              if (s_reg.st == ST_WORD) begin
                s_next.ptr = s_reg.sh;
              end else begin
                // protected bytes are still acknowledged, the data is dropped
                if (!wr_blocked && !s_reg.map) begin
                  s_next.id_mem[s_reg.ptr] = s_reg.sh;
                end
                if (!wr_blocked && s_reg.map) begin
                  s_next.dg_mem[s_reg.ptr[6:0]] = s_reg.sh;
                end
                s_next.ptr = s_reg.ptr + 8'h01;
              end
            end
          end
        end
        ST_ACK_A: begin
          if (scl_fall) begin
            load_rd = s_reg.rw;
            if (!s_reg.rw) begin
              s_next.sda_oe_n = 1'b1;
              s_next.st       = ST_WORD;
            end
          end
        end
        ST_ACK_B: begin
          if (scl_fall) begin
            s_next.sda_oe_n = 1'b1;
            s_next.st       = ST_WRITE;
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s_reg.cnt == 4'h8) begin
              s_next.sda_oe_n = 1'b1;
              s_next.st       = ST_RACK;
            end else begin
              s_next.sh       = {s_reg.sh[6:0], 1'b0};
              s_next.sda_oe_n = s_reg.sh[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            s_next.nack = s_reg.sda.s;
          end else if (scl_fall) begin
            load_rd = !s_reg.nack;
            if (s_reg.nack) begin
              s_next.st = ST_IDLE;
            end
          end
        end
        default: begin
          s_next.st       = ST_IDLE;
          s_next.sda_oe_n = 1'b1;
        end
      endcase
    end

    if (load_rd) begin
      rbyte           = rd_byte(s_reg, s_reg.map, s_reg.ptr);
      s_next.sh       = rbyte;
      s_next.ptr      = s_reg.ptr + 8'h01;
      s_next.sda_oe_n = rbyte[7];
      s_next.cnt      = 4'h0;
      s_next.st       = ST_READ;
    end

    s_next.alm = alm_c;
    s_next.wrn = wrn_c;

    // register slave; a host byte store in the same cycle holds the answer back by one
    wb_hit         = wb_i.cyc && wb_i.stb && !s_reg.rsp.ack && !i2c_store;
    s_next.rsp.ack = wb_hit;
    s_next.rsp.dat = 32'h0;
    if (wb_hit) begin
      unique case (wb_i.adr)
        REG_CTRL:     rd = {29'h0, s_reg.ctrl};
        REG_PINS:     rd = {27'h0, s_reg.txd.s, s_reg.tx_en, s_reg.fault.s, s_reg.rx_signal_lost_out, s_reg.rx_data};
        REG_IRQ_STAT: rd = {28'h0, s_reg.irq_stat};
        REG_IRQ_MASK: rd = {28'h0, s_reg.irq_mask};
        REG_FLAGS:    rd = {6'h0, s_reg.wrn, 6'h0, s_reg.alm};
        REG_MEM_ADDR: rd = {23'h0, s_reg.mem_sel, s_reg.mem_adr};
        REG_MEM_DATA: rd = {24'h0, rd_byte(s_reg, s_reg.mem_sel, s_reg.mem_adr)};
        default:      rd = 32'h0;
      endcase
      for (int p = 0; p < NUM_MON; p++) begin
        if (wb_i.adr == REG_MON_BASE + 8'(4*p)) begin
          rd = {16'h0, s_reg.mon[p]};
        end
      end
      if (wb_i.we) begin
        if (wb_i.adr == REG_CTRL) begin
          s_next.ctrl = 3'((rd & ~wm) | (wb_i.dat & wm));
        end
        if (wb_i.adr == REG_IRQ_MASK) begin
          s_next.irq_mask = 4'((rd & ~wm) | (wb_i.dat & wm));
        end
        if (wb_i.adr == REG_IRQ_STAT) begin
          clr = 4'(wb_i.dat & wm);
        end
        if (wb_i.adr == REG_MEM_ADDR) begin
          {s_next.mem_sel, s_next.mem_adr} = 9'((rd & ~wm) | (wb_i.dat & wm));
        end
        if (wb_i.adr == REG_MEM_DATA && wb_i.sel[0] && !s_reg.mem_sel) begin
          s_next.id_mem[s_reg.mem_adr] = wb_i.dat[7:0];
        end
        if (wb_i.adr == REG_MEM_DATA && wb_i.sel[0] && s_reg.mem_sel && !s_reg.mem_adr[7]) begin
          s_next.dg_mem[s_reg.mem_adr[6:0]] = wb_i.dat[7:0];
        end
        for (int p = 0; p < NUM_MON; p++) begin
          if (wb_i.adr == REG_MON_BASE + 8'(4*p)) begin
            s_next.mon[p] = 16'((rd & ~wm) | (wb_i.dat & wm));
          end
        end
      end else begin
        s_next.rsp.dat = rd;
      end
      if (wb_i.adr == REG_MEM_DATA) begin
        s_next.mem_adr = s_reg.mem_adr + 8'h01;
      end
    end

    // a fresh event outranks a clear in the same cycle
    ev[IRQ_HOST_WR] = i2c_store && !wr_blocked;
    ev[IRQ_FAULT]   = s_reg.fault.s && !s_reg.fault_d;
    ev[IRQ_LOS]     = s_reg.sd.s != s_reg.sd_d;
    ev[IRQ_ALARM]   = |(alm_c & ~s_reg.alm);
    s_next.irq_stat = (s_reg.irq_stat & ~clr) | ev;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);

    s_next.tx_fault = s_reg.fault.s || s_reg.alm[ALM_BIAS_HI];
    s_next.tx_en    = !s_reg.txd.s && !s_reg.ctrl[CTRL_SOFT_TXOFF];
    s_next.rx_signal_lost_out      = !s_reg.sd.s;
    s_next.rx_data  = s_reg.rxd.s && s_reg.sd.s;

    if (rst_i) begin
      s_next          = '0;
      s_next.scl      = '{m: 1'b1, s: 1'b1};
      s_next.sda      = '{m: 1'b1, s: 1'b1};
      s_next.scl_d    = 1'b1;
      s_next.sda_d    = 1'b1;
      // laser starts off: the disable pin is treated as high until it is seen
      s_next.txd      = '{m: 1'b1, s: 1'b1};
      s_next.st       = ST_IDLE;
      s_next.sda_oe_n = 1'b1;
      s_next.ctrl     = CTRL_RESET;
      s_next.rx_signal_lost_out      = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign wb_o                  = s_reg.rsp;
  assign sda_o                 = 1'b0;
  assign sda_oe_n_o            = s_reg.sda_oe_n;
  assign module_present_pin_o  = 1'b0;
  assign module_present_oe_n_o = 1'b0;
  assign tx_fault_o            = s_reg.tx_fault;
  assign tx_laser_en_o         = s_reg.tx_en;
  assign rx_signal_lost_out_o  = s_reg.rx_signal_lost_out;
  assign rx_data_o             = s_reg.rx_data;
  assign irq_o                 = s_reg.irq;

  logic [10:0] off_wait;
  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_disable_i || !tx_laser_en_o) begin
      off_wait <= 11'h000;
    end else begin
      off_wait <= off_wait + 11'h001;
    end
  end

  a_tx_off_time: assert property (@(posedge clk_i) disable iff (rst_i) off_wait < 11'(TX_OFF_MAX_CYC))
    else $error("laser still on too long after disable");
  a_tx_off_sync: assert property (@(posedge clk_i) disable iff (rst_i) tx_disable_i [*3] |=> !tx_laser_en_o)
    else $error("laser not off after disable input high");
  a_tx_on_cause: assert property (@(posedge clk_i) disable iff (rst_i) tx_laser_en_o |-> !$past(tx_disable_i, 3))
    else $error("laser on without low disable input");
  a_los_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rst_i, 3) |-> rx_signal_lost_out_o == !$past(rx_signal_detect_i, 3))
    else $error("signal-lost output does not follow detect");
  a_rx_gate: assert property (@(posedge clk_i) disable iff (rst_i) rx_signal_lost_out_o |-> !rx_data_o)
    else $error("received data passed while signal lost");
  a_fault_out: assert property (@(posedge clk_i) disable iff (rst_i) s_reg.fault.s |=> tx_fault_o)
    else $error("laser fault not reported");
  a_present_gnd: assert property (@(posedge clk_i) !module_present_pin_o && !module_present_oe_n_o)
    else $error("module-present pin not grounded");
  a_sda_on_fall: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(sda_oe_n_o) |-> $past(scl_fall) || $past(bus_start) || $past(bus_stop))
    else $error("data line changed outside a clock fall");
  a_addr_ack: assert property (@(posedge clk_i) disable iff (rst_i)
      s_reg.st == ST_ADDR && byte_done && !bus_start && !bus_stop && dev_match(s_reg.sh[7:1])
      |=> !sda_oe_n_o && s_reg.map == $past(s_reg.sh[1]))
    else $error("own address not acknowledged");
  a_addr_other: assert property (@(posedge clk_i) disable iff (rst_i)
      s_reg.st == ST_ADDR && byte_done && !bus_start && !bus_stop && !dev_match(s_reg.sh[7:1])
      |=> sda_oe_n_o && s_reg.st == ST_IDLE)
    else $error("foreign address acknowledged");
  a_ptr_incr: assert property (@(posedge clk_i) disable iff (rst_i)
      i2c_store |=> s_reg.ptr == $past(s_reg.ptr) + 8'h01)
    else $error("word address did not advance");
  a_prot_write: assert property (@(posedge clk_i) disable iff (rst_i)
      i2c_store && wr_blocked && !s_reg.map |=> $stable(s_reg.id_mem))
    else $error("protected identification byte changed");
  a_alarm_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      s_reg.mon[0] > thr(s_reg.dg_mem, THR_HI_ALM) |=> s_reg.alm[9])
    else $error("high alarm flag missing");
  a_wb_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_i.cyc && wb_i.stb && !wb_o.ack |-> ##[1:2] wb_o.ack)
    else $error("register access not answered");
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o == $past(|(s_next.irq_stat & s_next.irq_mask)))
    else $error("interrupt output wrong");

endmodule // omp_mgmt_port

// File: omp_host_model.sv
module omp_host_model (
  input  wire logic clk_i,
  input  wire logic dev_sda_i,
  input  wire logic dev_sda_oe_n_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_sda;
  // pulled-up open-drain line, low when either side pulls it
  assign sda_o = drv_sda & (dev_sda_oe_n_i | dev_sda_i);
  initial begin
    scl_o = 1'b1;
    drv_sda = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // host alone makes the serial clock, 8 + 8 cycles per bit
  task automatic start();
    drv_sda <= 1'b1;
    wt(8);
    scl_o <= 1'b1;
    wt(8);
    drv_sda <= 1'b0;
    wt(8);
    scl_o <= 1'b0;
    wt(2);
  endtask
  task automatic stop();
    drv_sda <= 1'b0;
    wt(8);
    scl_o <= 1'b1;
    wt(8);
    drv_sda <= 1'b1;
    wt(8);
  endtask
  // data changes only while the clock is low, sampled mid-high
  task automatic bit_x(input logic b, output logic r);
    drv_sda <= b;
    wt(6);
    scl_o <= 1'b1;
    wt(4);
    r = sda_o;
    wt(4);
    scl_o <= 1'b0;
    wt(2);
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic nk);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(last, nk);
  endtask
endmodule // omp_host_model

// File: omp_mgmt_port_tb_top.sv
module omp_mgmt_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import omp_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  omp_wb_req_t wb_req = '0;
  omp_wb_rsp_t wb_rsp;
  logic        scl, sda, dev_sda, dev_oe_n, mp_pin, mp_oe_n;
  logic        fault = 1'b0;
  logic        txdis = 1'b1; // open input modelled by the pull-up
  logic        sig_det = 1'b0;
  logic        rxd = 1'b0;
  logic        tx_fault, laser_en, rx_signal_lost_out, rxd_out, irq, nk;
  logic [7:0]  q;
  logic [31:0] rd;
  int          n_fail = 0;
  int          samples_checked = 0;
  always #5 clk_i = ~clk_i;
  omp_mgmt_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .wb_o(wb_rsp), .scl_i(scl), .sda_i(sda),
    .sda_o(dev_sda), .sda_oe_n_o(dev_oe_n), .module_present_pin_o(mp_pin), .module_present_oe_n_o(mp_oe_n),
    .laser_fault_i(fault), .tx_fault_o(tx_fault), .tx_disable_i(txdis), .tx_laser_en_o(laser_en),
    .rx_signal_detect_i(sig_det), .rx_data_i(rxd), .rx_signal_lost_out_o(rx_signal_lost_out), .rx_data_o(rxd_out), .irq_o(irq));
  omp_host_model host_u (.clk_i(clk_i), .dev_sda_i(dev_sda), .dev_sda_oe_n_i(dev_oe_n), .scl_o(scl), .sda_o(sda));
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // entered just after a rising edge; holds the request until ack is sampled
  task automatic wb_acc(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_rsp.ack === 1'b1) break;
    end
    rd = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk_i);
    if (i == 20) begin
      n_fail++;
      $display("unexpected at %0t: no bus ack", $time);
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_acc(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb_acc(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic hx(input logic [7:0] d, input logic last, input logic exp_nk);
    host_u.xfer(d, last, q, nk);
    chk({31'h0, nk}, {31'h0, exp_nk});
  endtask
  task automatic id_wr();
    host_u.start();
    hx(8'ha0, 1'b1, 1'b0);
    hx(8'h05, 1'b1, 1'b0);
    hx(8'haa, 1'b1, 1'b0);
    host_u.stop();
    wr(REG_MEM_ADDR, 32'h5);
  endtask
  initial begin
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    chk({30'h0, mp_pin, mp_oe_n}, 32'h0);
    rd_chk(REG_CTRL, 32'h1);
    rd_chk(REG_PINS, 32'h12);
    rd_chk(8'h3c, 32'h0);
    wr(REG_IRQ_STAT, 32'hf);
    txdis <= 1'b0;
    tick(8);
    chk({31'h0, laser_en}, 32'h1);
    wr(REG_CTRL, 32'h5);
    tick(8);
    chk({31'h0, laser_en}, 32'h0);
    wr(REG_CTRL, 32'h1);
    txdis <= 1'b1;
    tick(8);
    chk({31'h0, laser_en}, 32'h0);
    wr(REG_IRQ_MASK, 32'h2);
    fault <= 1'b1;
    tick(8);
    chk({30'h0, tx_fault, irq}, 32'h3);
    rd_chk(REG_IRQ_STAT, 32'h2);
    wr(REG_IRQ_STAT, 32'h2);
    fault <= 1'b0;
    tick(8);
    chk({30'h0, tx_fault, irq}, 32'h0);
    wr(REG_MON_BASE + 8'h08, 32'h1);
    tick(8);
    chk({31'h0, tx_fault}, 32'h1); // bias above its alarm level
    wr(REG_MON_BASE + 8'h08, 32'h0);
    sig_det <= 1'b1;
    rxd <= 1'b1;
    tick(8);
    chk({29'h0, tx_fault, rx_signal_lost_out, rxd_out}, 32'h1);
    sig_det <= 1'b0;
    tick(8);
    chk({30'h0, rx_signal_lost_out, rxd_out}, 32'h2);
    wr(REG_MON_BASE, 32'h1234);
    tick(2);
    rd_chk(REG_FLAGS, 32'h0200_0200);
    host_u.start();
    hx(8'ha2, 1'b1, 1'b0);
    hx(8'h00, 1'b1, 1'b0);
    hx(8'hff, 1'b1, 1'b0);
    hx(8'hff, 1'b1, 1'b0);
    host_u.stop();
    rd_chk(REG_FLAGS, 32'h0200_0000);
    wr(REG_MEM_ADDR, 32'h100);
    rd_chk(REG_MEM_DATA, 32'hff);
    rd_chk(REG_MEM_DATA, 32'hff);
    host_u.start();
    hx(8'ha2, 1'b1, 1'b0);
    hx(8'h60, 1'b1, 1'b0);
    host_u.start();
    hx(8'ha3, 1'b1, 1'b0);
    hx(8'hff, 1'b0, 1'b0);
    chk({24'h0, q}, 32'h12);
    hx(8'hff, 1'b1, 1'b1);
    chk({24'h0, q}, 32'h34);
    host_u.stop();
    id_wr();
    rd_chk(REG_MEM_DATA, 32'h0); // write-protected byte kept
    wr(REG_CTRL, 32'h0);
    wr(REG_IRQ_STAT, 32'hf);
    id_wr();
    rd_chk(REG_MEM_DATA, 32'haa);
    rd_chk(REG_IRQ_STAT, 32'h1);
    wr(REG_CTRL, 32'h2);
    wr(REG_MEM_ADDR, 32'h128);
    wr(REG_MEM_DATA, 32'h5a);
    host_u.start();
    hx(8'ha2, 1'b1, 1'b0);
    hx(8'h28, 1'b1, 1'b0);
    hx(8'hc3, 1'b1, 1'b0); // diag map protected: acked, dropped
    host_u.stop();
    wr(REG_MEM_ADDR, 32'h128);
    rd_chk(REG_MEM_DATA, 32'h5a);
    host_u.start();
    hx(8'ha4, 1'b1, 1'b1);
    host_u.stop();
    test_done();
  end
endmodule // omp_mgmt_port_tb_top
